/* shared/srl_pkg.sv */
// Package with register map, field positions and timing constants of the set-reset latch unit
package srl_pkg;
    localparam int unsigned ADDR_W            = 4;
    localparam int unsigned DATA_W            = 32;
    // Register byte addresses
    localparam logic [3:0]  CTRL0_ADDR        = 4'h0;
    localparam logic [3:0]  CTRL1_ADDR        = 4'h4;
    localparam logic [3:0]  STATUS_ADDR       = 4'h8;
    // Control zero fields
    localparam int unsigned C0_MASTER_EN      = 7;
    localparam int unsigned C0_DIV_HI         = 6;
    localparam int unsigned C0_DIV_LO         = 4;
    localparam int unsigned C0_TRUE_OE        = 3;
    localparam int unsigned C0_INV_OE         = 2;
    localparam int unsigned C0_SOFT_SET       = 1;
    localparam int unsigned C0_SOFT_RST       = 0;
    // Control one fields
    localparam int unsigned C1_SET_SOFT       = 7;
    localparam int unsigned C1_SET_PULSE      = 6;
    localparam int unsigned C1_SET_CMP2       = 5;
    localparam int unsigned C1_SET_CMP1       = 4;
    localparam int unsigned C1_RST_SOFT       = 3;
    localparam int unsigned C1_RST_PULSE      = 2;
    localparam int unsigned C1_RST_CMP2       = 1;
    localparam int unsigned C1_RST_CMP1       = 0;
    localparam int unsigned C1_SET_PIN        = 8;
    localparam int unsigned C1_RST_PIN        = 9;
    localparam int unsigned C1_CMP1_SYNC      = 10;
    localparam int unsigned C1_CMP2_SYNC      = 11;
    localparam int unsigned CTRL0_W           = 8;
    localparam int unsigned CTRL1_W           = 12;
    localparam logic [7:0]  CTRL0_RESET       = 8'h00;
    localparam logic [11:0] CTRL1_RESET       = 12'h000;
    // Status fields
    localparam int unsigned ST_TRUE           = 0;
    localparam int unsigned ST_INV            = 1;
    // Pulse divider: code 0 divides by 4, each code doubles
    localparam int unsigned DIV_W             = 3;
    localparam int unsigned DIV_CNT_W         = 9;
    localparam int unsigned DIV_BASE_SHIFT    = 2;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage : srl_pkg

/* verilog/srl_sync2.sv */
// Two-flop synchroniser for asynchronous single-bit inputs
`timescale 1ns/1ps
module srl_sync2 (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;
    logic nxt_meta;
    logic sync_ff;
    logic nxt_sync;

    always_comb begin
        nxt_meta = din;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign dout = sync_ff;
endmodule : srl_sync2

/* verilog/srl_pulse_gen.sv */
// Free-running divider giving one-cycle pulses every 4 to 512 clocks
`timescale 1ns/1ps
module srl_pulse_gen (
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire logic [srl_pkg::DIV_W-1:0]      div_sel,
    output logic                                pulse
);
    logic [srl_pkg::DIV_CNT_W-1:0] cnt_ff;
    logic [srl_pkg::DIV_CNT_W-1:0] nxt_cnt;
    logic [srl_pkg::DIV_CNT_W-1:0] wrap_val;
    logic                          pulse_ff;
    logic                          nxt_pulse;

    always_comb begin
        wrap_val = srl_pkg::DIV_CNT_W'((1 << (int'(div_sel) + srl_pkg::DIV_BASE_SHIFT)) - 1);
        // Counter at or past the wrap value after a code change also wraps, so no long stall
        if (cnt_ff >= wrap_val) begin
            nxt_cnt   = '0;
            nxt_pulse = 1'b1;
        end else begin
            nxt_cnt   = cnt_ff + 1'b1;
            nxt_pulse = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_ff   <= '0;
            pulse_ff <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            pulse_ff <= nxt_pulse;
        end
    end

    assign pulse = pulse_ff;
endmodule : srl_pulse_gen

/* verilog/srl_latch_unit.sv */
// Set-reset latch unit with selectable sources, pin outputs and AXI4-Lite registers
// Operation
// - One latch, many inputs, true and inverted
// - Inputs active high, latch needs no clock (here a flop clocked by clk)
// - Soft, comparators, pin, pulse select set/reset
// - Reset wins when set and reset high
// - Soft pulse bits self clear after acting
// - Comparator inputs optionally timer-synchronised
// - Three-bit divider, separate set/reset pulse enables
// - Independent enables route both outputs to pins
// - Pulse one cycle, every 4th to 512th
// - Latch state not forced at reset
// - Master enable off disables latch and pins
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module srl_latch_unit (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cmp_one_out,
    input  wire logic        cmp_two_out,
    input  wire logic        timer_one_clk_en,
    input  wire logic        latch_ext_input_pin,
    output logic             latch_true_pin,
    output logic             latch_true_pin_oe,
    output logic             latch_inv_pin,
    output logic             latch_inv_pin_oe
);
    // Sync map: 0 comparator one, 1 comparator two, 2 latch input pin, 3 timer tick
    localparam int unsigned N_ASYNC = 4;
    logic [7:0]  ctrl0_ff;
    logic [7:0]  nxt_ctrl0;
    logic [11:0] ctrl1_ff;
    logic [11:0] nxt_ctrl1;
    logic        soft_set_pulse_ff;
    logic        nxt_soft_set_pulse;
    logic        soft_reset_pulse_ff;
    logic        nxt_soft_reset_pulse;
    logic        aw_held_ff;
    logic        nxt_aw_held;
    logic [3:0]  aw_addr_ff;
    logic [3:0]  nxt_aw_addr;
    logic        w_held_ff;
    logic        nxt_w_held;
    logic [31:0] w_data_ff;
    logic [31:0] nxt_w_data;
    logic [3:0]  w_strb_ff;
    logic [3:0]  nxt_w_strb;
    logic        bvalid_ff;
    logic        nxt_bvalid;
    logic [1:0]  bresp_ff;
    logic [1:0]  nxt_bresp;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0]  rresp_ff;
    logic [1:0]  nxt_rresp;
    logic        cmp1_sync_ff;
    logic        nxt_cmp1_sync;
    logic        cmp2_sync_ff;
    logic        nxt_cmp2_sync;
    logic        latch_q_ff;
    logic        nxt_latch_q;
    logic        true_pin_ff;
    logic        nxt_true_pin;
    logic        true_oe_ff;
    logic        nxt_true_oe;
    logic        inv_pin_ff;
    logic        nxt_inv_pin;
    logic        inv_oe_ff;
    logic        nxt_inv_oe;
    logic        awready_ff;
    logic        nxt_awready;
    logic        wready_ff;
    logic        nxt_wready;
    logic        arready_ff;
    logic        nxt_arready;
    logic [N_ASYNC-1:0] async_in;
    logic [N_ASYNC-1:0] async_sync;
    logic        cmp1_meta;
    logic        cmp2_meta;
    logic        pin_meta;
    logic        timer_en_meta;
    logic        periodic_pulse;
    logic        cmp_one_synced_out;
    logic        cmp_two_synced_out;
    logic        set_in;
    logic        reset_in;
    logic        do_write;
    logic [31:0] wr_mask;

    // Every asynchronous outside input (comparators, latch input pin, timer tick) passes two flops before use
    assign async_in = {timer_one_clk_en, latch_ext_input_pin, cmp_two_out, cmp_one_out};
    for (genvar g = 0; g < N_ASYNC; g++) begin : g_sync
        srl_sync2 u_sync (
            .clk   (clk),
            .reset (reset),
            .din   (async_in[g]),
            .dout  (async_sync[g])
        );
    end
    assign cmp1_meta     = async_sync[0];
    assign cmp2_meta     = async_sync[1];
    assign pin_meta      = async_sync[2];
    assign timer_en_meta = async_sync[3];

    srl_pulse_gen u_pulse (
        .clk     (clk),
        .reset   (reset),
        .div_sel (ctrl0_ff[srl_pkg::C0_DIV_HI:srl_pkg::C0_DIV_LO]),
        .pulse   (periodic_pulse)
    );

    // Comparator path: direct, or resampled on general timer one clock ticks
    always_comb begin
        nxt_cmp1_sync = timer_en_meta ? cmp1_meta : cmp1_sync_ff;
        nxt_cmp2_sync = timer_en_meta ? cmp2_meta : cmp2_sync_ff;
        cmp_one_synced_out = ctrl1_ff[srl_pkg::C1_CMP1_SYNC] ? cmp1_sync_ff : cmp1_meta;
        cmp_two_synced_out = ctrl1_ff[srl_pkg::C1_CMP2_SYNC] ? cmp2_sync_ff : cmp2_meta;
    end

    // Source selection, all active high
    always_comb begin
        set_in = (ctrl1_ff[srl_pkg::C1_SET_SOFT]  & soft_set_pulse_ff)
               | (ctrl1_ff[srl_pkg::C1_SET_PULSE] & periodic_pulse)
               | (ctrl1_ff[srl_pkg::C1_SET_CMP1]  & cmp_one_synced_out)
               | (ctrl1_ff[srl_pkg::C1_SET_CMP2]  & cmp_two_synced_out)
               | (ctrl1_ff[srl_pkg::C1_SET_PIN]   & pin_meta);
        reset_in = (ctrl1_ff[srl_pkg::C1_RST_SOFT]  & soft_reset_pulse_ff)
                 | (ctrl1_ff[srl_pkg::C1_RST_PULSE] & periodic_pulse)
                 | (ctrl1_ff[srl_pkg::C1_RST_CMP1]  & cmp_one_synced_out)
                 | (ctrl1_ff[srl_pkg::C1_RST_CMP2]  & cmp_two_synced_out)
                 | (ctrl1_ff[srl_pkg::C1_RST_PIN]   & pin_meta);
    end

    // Latch modelled as a flop so it stays synthesizable; it holds without a clock edge in intent
    always_comb begin
        nxt_latch_q = latch_q_ff;
        if (ctrl0_ff[srl_pkg::C0_MASTER_EN]) begin
            if (reset_in) begin
                nxt_latch_q = 1'b0;
            end else if (set_in) begin
                nxt_latch_q = 1'b1;
            end
        end
        nxt_true_pin = latch_q_ff;
        nxt_inv_pin  = ~latch_q_ff;
        nxt_true_oe  = ctrl0_ff[srl_pkg::C0_MASTER_EN] & ctrl0_ff[srl_pkg::C0_TRUE_OE];
        nxt_inv_oe   = ctrl0_ff[srl_pkg::C0_MASTER_EN] & ctrl0_ff[srl_pkg::C0_INV_OE];
    end

    // Latch state has no reset; firmware must initialise it
    always_ff @(posedge clk) begin
        latch_q_ff <= nxt_latch_q;
    end

    // AXI4-Lite write and read channels plus control registers
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held  = w_held_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        nxt_ctrl0   = ctrl0_ff;
        nxt_ctrl1   = ctrl1_ff;
        // Soft pulses last one cycle, then clear themselves
        nxt_soft_set_pulse   = 1'b0;
        nxt_soft_reset_pulse = 1'b0;
        wr_mask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
        if (s_axi_awvalid && !aw_held_ff) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_ff) begin
            nxt_w_held = 1'b1;
            nxt_w_data = s_axi_wdata;
            nxt_w_strb = s_axi_wstrb;
        end
        do_write = aw_held_ff && w_held_ff && !bvalid_ff;
        if (do_write) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = srl_pkg::RESP_OKAY;
            case (aw_addr_ff)
                srl_pkg::CTRL0_ADDR: begin
                    nxt_ctrl0 = (ctrl0_ff & ~wr_mask[7:0]) | (w_data_ff[7:0] & wr_mask[7:0]);
                    nxt_ctrl0[srl_pkg::C0_SOFT_SET] = 1'b0;
                    nxt_ctrl0[srl_pkg::C0_SOFT_RST] = 1'b0;
                    nxt_soft_set_pulse   = wr_mask[srl_pkg::C0_SOFT_SET] & w_data_ff[srl_pkg::C0_SOFT_SET];
                    nxt_soft_reset_pulse = wr_mask[srl_pkg::C0_SOFT_RST] & w_data_ff[srl_pkg::C0_SOFT_RST];
                end
                srl_pkg::CTRL1_ADDR: begin
                    nxt_ctrl1 = (ctrl1_ff & ~wr_mask[11:0]) | (w_data_ff[11:0] & wr_mask[11:0]);
                end
                srl_pkg::STATUS_ADDR: begin
                    nxt_bresp = srl_pkg::RESP_OKAY;
                end
                default: begin
                    nxt_bresp = srl_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = srl_pkg::RESP_OKAY;
            nxt_rdata  = '0;
            case (s_axi_araddr)
                srl_pkg::CTRL0_ADDR:  nxt_rdata[7:0]  = ctrl0_ff;   // Pulse bits always read zero
                srl_pkg::CTRL1_ADDR:  nxt_rdata[11:0] = ctrl1_ff;
                srl_pkg::STATUS_ADDR: begin
                    nxt_rdata[srl_pkg::ST_TRUE] = latch_q_ff;
                    nxt_rdata[srl_pkg::ST_INV]  = ~latch_q_ff;
                end
                default:              nxt_rresp = srl_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        // Ready kept in its own flop so the port leaves a register; awready and wready are the inverse of the held flags, arready of rvalid
        nxt_awready = ~nxt_aw_held;
        nxt_wready  = ~nxt_w_held;
        nxt_arready = ~nxt_rvalid;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl0_ff            <= srl_pkg::CTRL0_RESET;
            ctrl1_ff            <= srl_pkg::CTRL1_RESET;
            soft_set_pulse_ff   <= 1'b0;
            soft_reset_pulse_ff <= 1'b0;
            aw_held_ff          <= 1'b0;
            aw_addr_ff          <= '0;
            w_held_ff           <= 1'b0;
            w_data_ff           <= '0;
            w_strb_ff           <= '0;
            bvalid_ff           <= 1'b0;
            bresp_ff            <= srl_pkg::RESP_OKAY;
            rvalid_ff           <= 1'b0;
            rdata_ff            <= '0;
            rresp_ff            <= srl_pkg::RESP_OKAY;
            cmp1_sync_ff        <= 1'b0;
            cmp2_sync_ff        <= 1'b0;
            true_pin_ff         <= 1'b0;
            true_oe_ff          <= 1'b0;
            inv_pin_ff          <= 1'b0;
            inv_oe_ff           <= 1'b0;
            awready_ff          <= 1'b1;
            wready_ff           <= 1'b1;
            arready_ff          <= 1'b1;
        end else begin
            ctrl0_ff            <= nxt_ctrl0;
            ctrl1_ff            <= nxt_ctrl1;
            soft_set_pulse_ff   <= nxt_soft_set_pulse;
            soft_reset_pulse_ff <= nxt_soft_reset_pulse;
            aw_held_ff          <= nxt_aw_held;
            aw_addr_ff          <= nxt_aw_addr;
            w_held_ff           <= nxt_w_held;
            w_data_ff           <= nxt_w_data;
            w_strb_ff           <= nxt_w_strb;
            bvalid_ff           <= nxt_bvalid;
            bresp_ff            <= nxt_bresp;
            rvalid_ff           <= nxt_rvalid;
            rdata_ff            <= nxt_rdata;
            rresp_ff            <= nxt_rresp;
            cmp1_sync_ff        <= nxt_cmp1_sync;
            cmp2_sync_ff        <= nxt_cmp2_sync;
            true_pin_ff         <= nxt_true_pin;
            true_oe_ff          <= nxt_true_oe;
            inv_pin_ff          <= nxt_inv_pin;
            inv_oe_ff           <= nxt_inv_oe;
            awready_ff          <= nxt_awready;
            wready_ff           <= nxt_wready;
            arready_ff          <= nxt_arready;
        end
    end

    // One write at a time keeps the slave simple
    assign s_axi_awready     = awready_ff;
    assign s_axi_wready      = wready_ff;
    assign s_axi_bvalid      = bvalid_ff;
    assign s_axi_bresp       = bresp_ff;
    assign s_axi_arready     = arready_ff;
    assign s_axi_rvalid      = rvalid_ff;
    assign s_axi_rdata       = rdata_ff;
    assign s_axi_rresp       = rresp_ff;
    assign latch_true_pin    = true_pin_ff;
    assign latch_true_pin_oe = true_oe_ff;
    assign latch_inv_pin     = inv_pin_ff;
    assign latch_inv_pin_oe  = inv_oe_ff;
endmodule : srl_latch_unit

/* dv/srl_far_side.sv */
// Far-side model: comparators, external latch input and timer tick
`timescale 1ns/1ps
module srl_far_side (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [2:0] want,
    input  wire logic       slow,
    output logic            cmp_one_out,
    output logic            cmp_two_out,
    output logic            latch_ext_input_pin,
    output logic            timer_one_clk_en
);
    logic [2:0] d1_ff;
    logic [2:0] d2_ff;
    logic [1:0] tick_ff;
    // Slow mode adds a lag, as a comparator settling would
    always_ff @(posedge clk) begin
        d1_ff <= want;
        d2_ff <= d1_ff;
        tick_ff <= (reset || tick_ff == 2'h2) ? 2'h0 : tick_ff + 2'h1;
    end
    // Active-high source levels
    assign {latch_ext_input_pin, cmp_two_out, cmp_one_out} = slow ? d2_ff : d1_ff;
    // Tick never stops, so a synced comparator always advances
    assign timer_one_clk_en = (tick_ff == 2'h0);
endmodule : srl_far_side

/* dv/srl_latch_unit_asserts.sv */
// Concurrent checks on the latch unit ports
`timescale 1ns/1ps
module srl_latch_unit_asserts (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        latch_true_pin,
    input wire logic        latch_true_pin_oe,
    input wire logic        latch_inv_pin,
    input wire logic        latch_inv_pin_oe
);
    logic [3:0] aw_ff;
    logic [7:0] wd_ff;
    always_ff @(posedge clk) begin
        if (s_axi_awvalid && s_axi_awready) aw_ff <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata[7:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_cmpl; latch_true_pin_oe |-> latch_inv_pin == !latch_true_pin; endproperty
    a_cmpl: assert property (p_cmpl) else $error("pins not complementary");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_wlat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
    endproperty
    a_wlat: assert property (p_wlat) else $error("write answer late");
    property p_bresp; $rose(s_axi_bvalid) |-> s_axi_bresp == ((aw_ff == srl_pkg::CTRL0_ADDR
        || aw_ff == srl_pkg::CTRL1_ADDR || aw_ff == srl_pkg::STATUS_ADDR) ? srl_pkg::RESP_OKAY : srl_pkg::RESP_SLVERR);
    endproperty
    a_bresp: assert property (p_bresp) else $error("bad write response");
    property p_oe;
        $rose(s_axi_bvalid) && aw_ff == srl_pkg::CTRL0_ADDR |-> ##[0:2]
            (latch_true_pin_oe == (wd_ff[7] && wd_ff[3]) && latch_inv_pin_oe == (wd_ff[7] && wd_ff[2]));
    endproperty
    a_oe: assert property (p_oe) else $error("pin enables wrong");
    property p_rst; $fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid && !latch_true_pin_oe && !latch_inv_pin_oe; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    c_err: cover property ($rose(s_axi_bvalid) && s_axi_bresp == srl_pkg::RESP_SLVERR);
    c_fall: cover property ($fell(latch_true_pin));
    c_oe: cover property ($rose(latch_inv_pin_oe));
endmodule : srl_latch_unit_asserts
bind srl_latch_unit srl_latch_unit_asserts i_chk (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .latch_true_pin, .latch_true_pin_oe,
    .latch_inv_pin, .latch_inv_pin_oe);

/* dv/srl_latch_unit_tb.sv */
// Self-checking bench for the set-reset latch unit
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module srl_latch_unit_tb;
    logic        clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, slow;
    logic        cmp_one_out, cmp_two_out, timer_one_clk_en, latch_ext_input_pin;
    logic        latch_true_pin, latch_true_pin_oe, latch_inv_pin, latch_inv_pin_oe;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  want;
    int          n_fail, n_checks, cyc, seed, n, k;
    logic [31:0] setb [3] = '{32'h010, 32'h020, 32'h100};
    logic [31:0] rstb [3] = '{32'h001, 32'h002, 32'h200};
    srl_latch_unit i_dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_one_out, .cmp_two_out,
        .timer_one_clk_en, .latch_ext_input_pin, .latch_true_pin, .latch_true_pin_oe, .latch_inv_pin,
        .latch_inv_pin_oe);
    srl_far_side i_far (.clk, .reset, .want, .slow, .cmp_one_out, .cmp_two_out, .latch_ext_input_pin,
        .timer_one_clk_en);
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    // Pulse sweep dominates the run, about 4k cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 40000) begin
            n_fail++;
            end_of_test();
        end
    end
    task end_of_test;
        if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // Responses stay ready throughout, so bready and rready are never toggled
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        `CHK("bresp", er, s_axi_bresp)
    endtask : wr
    task rdt(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        `CHK("rresp", er, s_axi_rresp)
        if (er == srl_pkg::RESP_OKAY) `CHK("rdata", e, s_axi_rdata)
    endtask : rdt
    task chk_q(input logic e, input int lim);
        n = 0;
        while (latch_true_pin !== e && n < lim) begin
            @(posedge clk);
            n++;
        end
        `CHK("q", e, latch_true_pin)
        `CHK("nq", !e, latch_inv_pin)
    endtask : chk_q
    task next_fall(output int c);
        c = 0;
        do begin @(posedge clk); c++; end while (latch_true_pin !== 1'b1 && c < 1100);
        do begin @(posedge clk); c++; end while (latch_true_pin !== 1'b0 && c < 1100);
    endtask : next_fall
    initial begin
        seed = 32'hd9f1b40f;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, slow} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, want} = 0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb, reset} = 7'h7F;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        // Latch starts unknown, so it is set before the pins are enabled
        wr(srl_pkg::CTRL1_ADDR, 32'h88, srl_pkg::RESP_OKAY);
        wr(srl_pkg::CTRL0_ADDR, 32'h82, srl_pkg::RESP_OKAY);
        chk_q(1'b1, 12);
        wr(srl_pkg::CTRL0_ADDR, 32'h8C, srl_pkg::RESP_OKAY);
        rdt(srl_pkg::CTRL0_ADDR, 32'h8C, srl_pkg::RESP_OKAY);
        rdt(srl_pkg::STATUS_ADDR, 32'h1, srl_pkg::RESP_OKAY);
        wr(srl_pkg::CTRL0_ADDR, 32'h8F, srl_pkg::RESP_OKAY);
        chk_q(1'b0, 12);
        rdt(srl_pkg::STATUS_ADDR, 32'h2, srl_pkg::RESP_OKAY);
        // One input per source at a time
        for (int i = 0; i < 3; i++) begin
            slow <= i[0];
            wr(srl_pkg::CTRL1_ADDR, setb[i] | 32'h408, srl_pkg::RESP_OKAY);
            want <= 3'h1 << i;
            chk_q(1'b1, 20);
            want <= 3'h0;
            wr(srl_pkg::CTRL1_ADDR, rstb[i] | 32'h480, srl_pkg::RESP_OKAY);
            want <= 3'h1 << i;
            chk_q(1'b0, 20);
            want <= 3'h0;
        end
        // Pin holds set high; each pulse wins for one cycle, dipping the pin
        want <= 3'h4;
        wr(srl_pkg::CTRL1_ADDR, 32'h104, srl_pkg::RESP_OKAY);
        for (int c = 0; c < 8; c++) begin
            wr(srl_pkg::CTRL0_ADDR, 32'h8C | (c << 4), srl_pkg::RESP_OKAY);
            repeat (2) next_fall(k);
            next_fall(k);
            `CHK("period", 4 << c, k)
        end
        want <= 3'h0;
        wr(srl_pkg::CTRL1_ADDR, 32'h48, srl_pkg::RESP_OKAY);
        wr(srl_pkg::CTRL0_ADDR, 32'hFD, srl_pkg::RESP_OKAY);
        chk_q(1'b0, 12);
        chk_q(1'b1, 530);
        wr(srl_pkg::CTRL1_ADDR, 32'h88, srl_pkg::RESP_OKAY);
        wr(srl_pkg::CTRL0_ADDR, 32'h0D, srl_pkg::RESP_OKAY);
        repeat (4) @(posedge clk);
        `CHK("oe", 1'b0, latch_true_pin_oe | latch_inv_pin_oe)
        rdt(srl_pkg::STATUS_ADDR, 32'h1, srl_pkg::RESP_OKAY);
        wr(4'hC, 32'hFF, srl_pkg::RESP_SLVERR);
        rdt(4'hC, 32'h0, srl_pkg::RESP_SLVERR);
        wr(srl_pkg::STATUS_ADDR, 32'h0, srl_pkg::RESP_OKAY);
        rdt(srl_pkg::STATUS_ADDR, 32'h1, srl_pkg::RESP_OKAY);
        // Master stays off, so random enables cannot disturb the latch
        repeat (4) begin
            rv = $random(seed) & 32'hFFF;
            wr(srl_pkg::CTRL1_ADDR, rv, srl_pkg::RESP_OKAY);
            rdt(srl_pkg::CTRL1_ADDR, rv, srl_pkg::RESP_OKAY);
            rv = $random(seed) & 32'h7C;
            wr(srl_pkg::CTRL0_ADDR, rv, srl_pkg::RESP_OKAY);
            rdt(srl_pkg::CTRL0_ADDR, rv, srl_pkg::RESP_OKAY);
        end
        end_of_test();
    end
endmodule : srl_latch_unit_tb
